// *** core/agc_group_ctrl.sv ***
// Register bank and data steering for converters 9 to 12
`timescale 1ns/1ps
module agc_group_ctrl
   import agc_pkg::*;
#(
   parameter int DW = 14
) (
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  clk_en,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Mode and pattern controls from elsewhere
   input  wire logic                  mode_16_input,
   input  wire logic                  individual_pattern_select,
   // Input pairs per converter, two candidates each
   input  wire logic [AGC_NCONV-1:0]  pair_even,
   input  wire logic [AGC_NCONV-1:0]  pair_odd,
   output logic      [AGC_NCONV-1:0]  conv_input_q,
   // Converter data and patterns per line
   input  wire logic [AGC_NCONV*DW-1:0] conv_data,
   input  wire logic [AGC_NCONV*DW-1:0] pattern_data,
   input  wire logic [AGC_NCONV-1:0]  group_pattern_on,
   output logic      [AGC_NCONV*DW-1:0] line_data_q,
   // Decoded controls
   output agc_ctrl_t                  ctrl_q,
   output logic [2*AGC_PAT_W-1:0]     pattern_code_q
);

   logic [15:0] select_q;
   logic [15:0] power_q;
   logic        wr_pend_q;
   logic        wr_power_q;
   logic        take;
   logic [AGC_NCONV-1:0] pat_on;

   assign take = hsel && hready && htrans == AGC_HTRANS_NONSEQ;

   // Zero wait state slave, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clk_en) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q  <= 1'b0;
         wr_power_q <= 1'b0;
      end else if (clk_en) begin
         wr_pend_q  <= 1'b0;
         if (take && hwrite && hsize == AGC_HSIZE_WORD) begin
            wr_pend_q  <= haddr[AGC_ADDR_W-1:0] == AGC_ADDR_SELECT ||
                          haddr[AGC_ADDR_W-1:0] == AGC_ADDR_POWER;
            wr_power_q <= haddr[AGC_ADDR_W-1:0] == AGC_ADDR_POWER;
         end
      end
   end

   // Read data registered at the address phase; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (clk_en && take && !hwrite) begin
         case (haddr[AGC_ADDR_W-1:0])
            AGC_ADDR_SELECT: hrdata <= {16'h0000, select_q};
            AGC_ADDR_POWER:  hrdata <= {16'h0000, power_q};
            default:         hrdata <= '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         select_q <= AGC_RST_SELECT;
         power_q  <= AGC_RST_POWER;
      end else if (clk_en && wr_pend_q) begin
         if (wr_power_q) begin
            power_q <= hwdata[15:0];
         end else begin
            select_q <= hwdata[15:0] & AGC_SELECT_MASK;
         end
      end
   end

   // Field decode, registered so outputs come from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q         <= '0;
         pattern_code_q <= '0;
      end else if (clk_en) begin
         // conv9 bit 11, conv10 bit 10
         // conv11 bit 9, conv12 bit 8
         ctrl_q.pair_select <= {select_q[AGC_PAIR_LSB],
                                select_q[AGC_PAIR_LSB+1],
                                select_q[AGC_PAIR_LSB+2],
                                select_q[AGC_PAIR_LSB+3]};
         ctrl_q.line11_pattern_code <=
            select_q[AGC_PAT11_LSB +: AGC_PAT_W];
         ctrl_q.line12_pattern_code <=
            select_q[AGC_PAT12_LSB +: AGC_PAT_W];
         pattern_code_q <= {select_q[AGC_PAT12_LSB +: AGC_PAT_W],
                            select_q[AGC_PAT11_LSB +: AGC_PAT_W]};
         // digital, line and analog power down, data flip
         // Lowest bit of each nibble belongs to converter or line 9
         ctrl_q.digital_off <= power_q[AGC_DIG_LSB +: AGC_NCONV];
         ctrl_q.line_off <= power_q[AGC_LINE_LSB +: AGC_NCONV];
         ctrl_q.analog_off <= power_q[AGC_ANA_LSB +: AGC_NCONV];
         ctrl_q.data_flip <= power_q[AGC_FLIP_LSB +: AGC_NCONV];
      end
   end

   // Individual codes only steer lines 11 and 12; lines 9 and 10 follow
   // the group pattern enable
   assign pat_on[0] = group_pattern_on[0];
   assign pat_on[1] = group_pattern_on[1];
   assign pat_on[2] = group_pattern_on[2] ||
      (individual_pattern_select && ctrl_q.line11_pattern_code != '0);
   assign pat_on[3] = group_pattern_on[3] ||
      (individual_pattern_select && ctrl_q.line12_pattern_code != '0);

   genvar i;
   generate
      for (i = 0; i < AGC_NCONV; i++) begin : g_conv
         // pair mux in 16-input mode; analog off holds the sample
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               conv_input_q[i] <= 1'b0;
            end else if (clk_en && !ctrl_q.analog_off[i]) begin
               conv_input_q[i] <= (mode_16_input && ctrl_q.pair_select[i]) ?
                                  pair_odd[i] : pair_even[i];
            end
         end

         agc_line_path #(
            .DW (DW)
         ) u_line (
            .hclk         (hclk),
            .hresetn      (hresetn),
            .clk_en       (clk_en && !ctrl_q.digital_off[i]),
            .pattern_on   (pat_on[i]),
            .data_flip    (ctrl_q.data_flip[i]),
            .line_off     (ctrl_q.line_off[i]),
            .conv_data    (conv_data[i*DW +: DW]),
            .pattern_data (pattern_data[i*DW +: DW]),
            .line_data_q  (line_data_q[i*DW +: DW])
         );
      end
   endgenerate

endmodule : agc_group_ctrl

// *** pkg/agc_pkg.sv ***
// Package for the converter 9-12 group control register bank
package agc_pkg;

   // Printed offsets are indices; byte address is four times the index
   localparam logic [7:0]  AGC_IDX_SELECT   = 8'h2f;
   localparam logic [7:0]  AGC_IDX_POWER    = 8'h30;
   localparam logic [9:0]  AGC_ADDR_SELECT  = {AGC_IDX_SELECT, 2'b00};
   localparam logic [9:0]  AGC_ADDR_POWER   = {AGC_IDX_POWER, 2'b00};
   localparam int          AGC_ADDR_W       = 10;

   localparam logic [15:0] AGC_RST_SELECT   = 16'h0000;
   localparam logic [15:0] AGC_RST_POWER    = 16'h0000;
   // Writable bits of the select register; 15-12 and 1-0 hold zero
   localparam logic [15:0] AGC_SELECT_MASK  = 16'h0ffc;

   localparam int          AGC_PAIR_LSB     = 8;
   localparam int          AGC_PAT11_LSB    = 5;
   localparam int          AGC_PAT12_LSB    = 2;
   localparam int          AGC_DIG_LSB      = 12;
   localparam int          AGC_LINE_LSB     = 8;
   localparam int          AGC_ANA_LSB      = 4;
   localparam int          AGC_FLIP_LSB     = 0;
   localparam int          AGC_NCONV        = 4;
   localparam int          AGC_PAT_W        = 3;

   localparam logic [1:0]  AGC_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  AGC_HSIZE_WORD    = 3'h2;

   // Index 0..3 stands for converter or line 9..12
   typedef struct packed {
      logic [3:0]           pair_select;
      logic [AGC_PAT_W-1:0] line11_pattern_code;
      logic [AGC_PAT_W-1:0] line12_pattern_code;
      logic [3:0]           digital_off;
      logic [3:0]           line_off;
      logic [3:0]           analog_off;
      logic [3:0]           data_flip;
   } agc_ctrl_t;

endpackage : agc_pkg

// *** core/agc_line_path.sv ***
// One serial output line: pattern override, inversion and power down
`timescale 1ns/1ps
module agc_line_path
   import agc_pkg::*;
#(
   parameter int DW = 14
) (
   // Clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          clk_en,
   // Controls
   input  wire logic          pattern_on,
   input  wire logic          data_flip,
   input  wire logic          line_off,
   // Data
   input  wire logic [DW-1:0] conv_data,
   input  wire logic [DW-1:0] pattern_data,
   output logic      [DW-1:0] line_data_q
);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_data_q <= '0;
      end else if (clk_en) begin
         if (line_off) begin
            line_data_q <= '0;
         end else if (pattern_on) begin
            line_data_q <= pattern_data;
         end else if (data_flip) begin
            line_data_q <= ~conv_data;
         end else begin
            line_data_q <= conv_data;
         end
      end
   end

endmodule : agc_line_path

// *** dv/agc_group_ctrl_properties.sv ***
// Port assertions for the converter 9-12 group control bank
`timescale 1ns/1ps
module agc_group_ctrl_properties
   import agc_pkg::*;
#(
   parameter int DW = 14
) (
   // Clock and reset
   input wire logic                    hclk,
   input wire logic                    hresetn,
   input wire logic                    clk_en,
   // Bus request
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [2:0]              hsize,
   input wire logic [31:0]             hwdata,
   input wire logic                    hready,
   // Steering and lines
   input wire logic                    mode_16_input,
   input wire logic [AGC_NCONV-1:0]    pair_even,
   input wire logic [AGC_NCONV-1:0]    pair_odd,
   input wire logic [AGC_NCONV-1:0]    conv_input_q,
   input wire logic [AGC_NCONV*DW-1:0] conv_data,
   input wire logic [AGC_NCONV-1:0]    group_pattern_on,
   input wire logic [AGC_NCONV*DW-1:0] line_data_q,
   input wire agc_ctrl_t               ctrl_q
);
   logic        acc;
   logic        acc_q;
   logic [15:0] wd_q;

   assign acc = clk_en && hsel && hready && htrans == AGC_HTRANS_NONSEQ &&
                hwrite && hsize == AGC_HSIZE_WORD && haddr[31:10] == '0;

   // Hold the data phase word so a check two cycles on still sees it
   always_ff @(posedge hclk) begin
      acc_q <= acc;
      if (acc_q) begin
         wd_q <= hwdata[15:0];
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_pair_write: assert property (
      acc && haddr[9:0] == AGC_ADDR_SELECT |-> ##[2:3]
      ctrl_q.pair_select == {wd_q[8], wd_q[9], wd_q[10], wd_q[11]})
      else $error("pair select field not stored");
   chk_code_write: assert property (
      acc && haddr[9:0] == AGC_ADDR_SELECT |-> ##[2:3]
      {ctrl_q.line11_pattern_code, ctrl_q.line12_pattern_code} == wd_q[7:2])
      else $error("pattern code fields not stored");
   chk_power_write: assert property (
      acc && haddr[9:0] == AGC_ADDR_POWER |-> ##[2:3]
      {ctrl_q.digital_off, ctrl_q.line_off, ctrl_q.analog_off,
       ctrl_q.data_flip} == wd_q)
      else $error("power register fields not stored");
   // Only judged while the decoded controls hold still
   chk_pair_route: assert property (
      clk_en && mode_16_input && ctrl_q.analog_off == '0 |=> $changed(ctrl_q)
      || conv_input_q == (($past(ctrl_q.pair_select) & $past(pair_odd)) |
                          (~$past(ctrl_q.pair_select) & $past(pair_even))))
      else $error("converter input pair wrong");
   chk_line_zero: assert property (
      clk_en && ctrl_q.line_off[0] |=> line_data_q[DW-1:0] == '0)
      else $error("line 9 not silent while off");
   chk_digital_hold: assert property (
      clk_en && ctrl_q.digital_off[0] && !ctrl_q.line_off[0] |=>
      $stable(line_data_q[DW-1:0]))
      else $error("line 9 moved while digital block off");
   chk_data_flip: assert property (
      clk_en && !group_pattern_on[0] && ctrl_q.line_off[0] == 1'b0 &&
      !ctrl_q.digital_off[0] |=> line_data_q[DW-1:0] ==
      ($past(ctrl_q.data_flip[0]) ? ~$past(conv_data[DW-1:0]) :
       $past(conv_data[DW-1:0])))
      else $error("line 9 data polarity wrong");
   chk_reset_clear: assert property (
      $rose(hresetn) |-> ctrl_q == '0 && conv_input_q == '0 &&
      line_data_q == '0)
      else $error("state not cleared by reset");
endmodule : agc_group_ctrl_properties

bind agc_group_ctrl agc_group_ctrl_properties #(.DW(DW))
   agc_group_ctrl_properties_i (.hclk, .hresetn, .clk_en, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .mode_16_input, .pair_even,
   .pair_odd, .conv_input_q, .conv_data, .group_pattern_on, .line_data_q,
   .ctrl_q);

// *** dv/agc_group_ctrl_tb_top.sv ***
// Self-checking bench for the converter 9-12 group control bank
`timescale 1ns/1ps
module agc_group_ctrl_tb_top
   import agc_pkg::*;
;
   localparam int DW = 14;
   logic            hclk, hresetn, hsel, hwrite, ind, hreadyout;
   logic            mode, ce;
   logic [1:0]      htrans;
   logic [3:0]      pair_even, gpo, sel, conv_input_q;
   logic [5:0]      pattern_code_q;
   logic [15:0]     v;
   logic [31:0]     haddr, hwdata, hrdata, junk;
   logic [4*DW-1:0] conv_data, pattern_data, line_data_q;
   int              n_fail, check_count, cyc;

   agc_group_ctrl #(.DW(DW)) agc_group_ctrl_i (
      .hclk, .hresetn, .clk_en(ce), .hsel, .haddr, .htrans, .hwrite,
      .hsize(AGC_HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp(), .mode_16_input(mode),
      .individual_pattern_select(ind),
      .pair_even, .pair_odd(4'ha), .conv_input_q, .conv_data, .pattern_data,
      .group_pattern_on(gpo), .line_data_q, .ctrl_q(), .pattern_code_q);

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // Hang guard: the full run needs a few hundred cycles at most
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         conclude();
      end
   end

   function automatic logic [31:0] ln(input logic [4*DW-1:0] b, input int i);
      return 32'(b[i*DW +: DW]);
   endfunction : ln

   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   // Single transfer; an idle edge follows so a read never meets a fresh write
   task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
                       output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {22'h0, a};
      htrans <= AGC_HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge hclk);
   endtask : xfer

   task automatic rc(input logic [9:0] a, input logic [15:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 16'h0, q);
      cmp("readback", {16'h0, e}, q);
   endtask : rc

   task automatic conclude();
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   initial begin
      {hresetn, hsel, hwrite, ind, htrans, haddr, hwdata, gpo} = '0;
      pair_even    = 4'h5;
      mode         = 1'b1;
      ce           = 1'b1;
      conv_data    = {4{14'h1234}};
      pattern_data = {4{14'h0c3a}};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rc(AGC_ADDR_SELECT, 16'h0);
      rc(AGC_ADDR_POWER, 16'h0);
      ind <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         v = {4'h0, 4'(k * 3), 3'(k), 3'(7 - k), 2'b00};
         xfer(1'b1, AGC_ADDR_SELECT, v, junk);
         rc(AGC_ADDR_SELECT, v);
         sel = {v[8], v[9], v[10], v[11]};
         cmp("pair", 32'((sel & 4'ha) | (~sel & pair_even)), 32'(conv_input_q));
         cmp("codes", 32'({3'(7 - k), 3'(k)}), 32'(pattern_code_q));
         cmp("line11", k != 0 ? ln(pattern_data, 2) : ln(conv_data, 2),
             ln(line_data_q, 2));
      end
      ind <= 1'b0;
      gpo <= 4'h2;
      xfer(1'b1, AGC_ADDR_POWER, 16'h000f, junk);
      rc(AGC_ADDR_POWER, 16'h000f);
      cmp("flip9", ln(~conv_data, 0), ln(line_data_q, 0));
      cmp("pat10", ln(pattern_data, 1), ln(line_data_q, 1));
      xfer(1'b1, AGC_ADDR_POWER, 16'h1010, junk);
      rc(AGC_ADDR_POWER, 16'h1010);
      conv_data <= {4{14'h2bcd}};
      pair_even <= 4'h4;
      repeat (3) @(posedge hclk);
      cmp("hold9", ln(~{4{14'h1234}}, 0), ln(line_data_q, 0));
      cmp("held9", 32'h1, 32'(conv_input_q[0]));
      xfer(1'b1, AGC_ADDR_POWER, 16'h0f00, junk);
      rc(AGC_ADDR_POWER, 16'h0f00);
      cmp("off12", 32'h0, ln(line_data_q, 3));
      xfer(1'b1, 10'h3fc, 16'hffff, junk);
      rc(10'h3fc, 16'h0);
      rc(AGC_ADDR_POWER, 16'h0f00);
      // Outside 16-input mode every converter takes its first pair
      mode <= 1'b0;
      repeat (3) @(posedge hclk);
      cmp("pair0", 32'h4, 32'(conv_input_q));
      // A write while the clock enable is low must leave no trace
      ce <= 1'b0;
      xfer(1'b1, AGC_ADDR_POWER, 16'h00f0, junk);
      ce <= 1'b1;
      rc(AGC_ADDR_POWER, 16'h0f00);
      conclude();
   end
endmodule : agc_group_ctrl_tb_top
